// ### logic/psm_indirect_on_off.sv
// Indirect peek/poke command handling and per-channel on/off control.
//
// Function
// - Peek: set indirect word, host 0, read port 0; bytes return upper zero.
// - Indirect value 0x0BF6 enables port 0 pokes; 0x01F6 disables them.
// - Indirect value 0x4BF6 enables port 1 pokes; 0x41F6 disables them.
// - Poke enable holds until disabled, power-up reset or watchdog reset.
// - Poke: enable, set indirect word, write data port to target location.
// - Pointer 0x2C page 0 host 0 reads back write-failed flag of port 0.
// - Port 1 serves all operations with host 1 and its own enable.
// - On/off-margin command works with pin per config; accepts page 0xFF.
// - Control 00 off now, 10 on, 01 sequence off; bits 1:0 read 00.
// - Margin 00/01/10 nominal/low/high; fault 01 ignore, 10 normal.
// - Config bit 3 low ignores bus on/off field but keeps margin.
// - Config bit 4 low powers up autonomously with sequencing.
// - Config bit 4 high with bits 3:2 zero never powers up.
// - Config bit 2 low ignores pin; high requires pin asserted to start.
// - Pin off uses turn-off delay, or immediate low with bit 0 set.
// - Config bits 7:5 ignore writes, read 0; bit 1 reads 1.
// - No sequencing until input voltage exceeds turn-on threshold.
// - Finish init within init time, then start turn-on delay.
// - Indirect page accepts 0 to 7, cached separately per data port.
// - Write-failed flag is 1 when last poke was rejected, else 0.
`timescale 1ns/10ps
module psm_indirect_on_off
    import psm_pkg::*;
#(
    parameter int CHANNELS          = 8,
    parameter int INIT_CYCLES       = INIT_TIME_US * 1000 / CLK_PERIOD_NS,
    parameter int TON_DELAY_CYCLES  = TON_DELAY_US * 1000 / CLK_PERIOD_NS,
    parameter int TOFF_DELAY_CYCLES = TOFF_DELAY_US * 1000 / CLK_PERIOD_NS
) (
    input  wire logic                  sys_clk,
    input  wire logic                  reset_n,
    input  wire logic                  cmdValid,
    input  wire logic                  cmdWrite,
    input  wire logic [7:0]            cmdCode,
    input  wire logic [7:0]            cmdPage,
    input  wire logic [15:0]           cmdWdata,
    output logic                       cmdRvalid,
    output logic [15:0]                cmdRdata,
    output logic                       cmdReject,
    input  wire logic                  onOffInputPin_n,
    input  wire logic                  watchdogInput,
    input  wire logic                  inputVoltageSenseOk,
    output logic [CHANNELS-1:0]        converterEnableOutput,
    output logic [2*CHANNELS-1:0]      marginSelect,
    output logic [CHANNELS-1:0]        faultsIgnored,
    output logic                       initDone
);
    localparam int CNT_W = 32;

    if (CHANNELS < 1 || CHANNELS > 8) begin : gBadChannels
        $error("CHANNELS must be 1 to 8");
    end
    if (INIT_CYCLES < 1 || TON_DELAY_CYCLES < 1 ||
        TOFF_DELAY_CYCLES < 1) begin : gBadDelays
        $error("Delay counts must be at least one cycle");
    end

    // Two-flop synchronisers for pin inputs.
    logic [2:0] syncA;
    logic [2:0] syncB;
    logic       wdiLast;
    always_ff @(posedge sys_clk) begin
        syncA <= {inputVoltageSenseOk, watchdogInput, onOffInputPin_n};
        syncB <= syncA;
        wdiLast <= syncB[1];
    end
    wire pinAsserted = ~syncB[0];
    wire wdiReset    = syncB[1] & ~wdiLast;
    wire vinOk       = syncB[2];

    // Initialisation timer after power-up.
    logic [CNT_W-1:0] initCount;
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            initCount <= '0;
            initDone  <= 1'b0;
        end else if (!initDone) begin
            initCount <= initCount + 1'b1;
            initDone  <= (initCount == CNT_W'(INIT_CYCLES - 1));
        end
    end
    wire seqReady = initDone & vinOk;

    // Command decode.
    wire isWr     = cmdValid & cmdWrite;
    wire isRd     = cmdValid & ~cmdWrite;
    wire isInd    = cmdCode == CODE_INDIRECT_CMD;
    wire isPort0  = cmdCode == CODE_DATA_PORT0;
    wire isPort1  = cmdCode == CODE_DATA_PORT1;
    wire isPort   = isPort0 | isPort1;
    wire hostSel  = isPort1;

    // Indirect state, cached per data port.
    logic [1:0] pokeEn;
    logic [1:0] pokeFailed;
    logic [8:0] ptrCache  [2];
    logic [4:0] pageCache [2];

    wire [8:0] indPtr   = ptrCache[hostSel];
    wire [4:0] indPage  = pageCache[hostSel];
    wire       pageLegal = indPage <= PAGE_MAX;
    wire       indHost  = cmdWdata[IND_HOST_BIT];
    wire       isEnDis  = cmdWdata == POKE_EN0 || cmdWdata == POKE_DIS0 ||
                          cmdWdata == POKE_EN1 || cmdWdata == POKE_DIS1;
    wire       isStatus = indPtr == PTR_STATUS0 || indPtr == PTR_STATUS1;
    wire       pokeReq  = isWr & isPort;
    wire       pokeOk   = pokeReq & pokeEn[hostSel] & pageLegal &
                          ~isStatus;

    always_ff @(posedge sys_clk) begin
        if (!reset_n || wdiReset) begin
            pokeEn <= 2'b00;
        end else if (isWr && isInd) begin
            if (cmdWdata == POKE_EN0) pokeEn[0] <= 1'b1;
            if (cmdWdata == POKE_DIS0) pokeEn[0] <= 1'b0;
            if (cmdWdata == POKE_EN1) pokeEn[1] <= 1'b1;
            if (cmdWdata == POKE_DIS1) pokeEn[1] <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ptrCache[0]  <= '0;
            ptrCache[1]  <= '0;
            pageCache[0] <= '0;
            pageCache[1] <= '0;
            pokeFailed   <= 2'b00;
        end else begin
            if (isWr && isInd && !isEnDis) begin
                ptrCache[indHost]  <= cmdWdata[IND_PTR_MSB:0];
                pageCache[indHost] <= cmdWdata[IND_PAGE_MSB:IND_PAGE_LSB];
            end
            if (pokeReq) begin
                pokeFailed[hostSel] <= ~pokeOk;
            end
        end
    end

    // Generic internal words reached by peek and poke.
    logic [15:0] userMem [4096];
    wire  [11:0] memIdx = {indPage[2:0], indPtr};
    wire         isOpPtr  = indPtr == {1'b0, CODE_ON_OFF_MARGIN};
    wire         isCfgPtr = indPtr == {1'b0, CODE_ON_OFF_CONFIG};
    always_ff @(posedge sys_clk) begin
        if (pokeOk && !isOpPtr && !isCfgPtr) begin
            userMem[memIdx] <= cmdWdata;
        end
    end

    // Unified write into the per-channel command registers.
    wire       directOp  = isWr & (cmdCode == CODE_ON_OFF_MARGIN);
    wire       directCfg = isWr & (cmdCode == CODE_ON_OFF_CONFIG);
    wire       wrOp      = directOp | (pokeOk & isOpPtr);
    wire       wrCfg     = directCfg | (pokeOk & isCfgPtr);
    wire [7:0] wrPage    = isPort ? {5'h00, indPage[2:0]} : cmdPage;
    wire [7:0] wrByte    = cmdWdata[7:0];
    wire [1:0] wrCtrl    = wrByte[OP_CTRL_LSB+:2];
    wire [1:0] wrMarg    = wrByte[OP_MARG_LSB+:2];
    wire [1:0] wrFlt     = wrByte[OP_FLT_LSB+:2];
    wire       opLegal   = wrCtrl != 2'h3 && wrMarg != 2'h3 &&
                           (wrMarg == MARG_NOMINAL || wrFlt == FLT_IGNORE ||
                            wrFlt == FLT_NORMAL);
    wire       pageOk    = wrPage == PAGE_GLOBAL ||
                           wrPage < 8'(CHANNELS);
    wire       directBad = (directOp && !opLegal) ||
                           ((directOp || directCfg) && !pageOk);

    logic [7:0] opReg  [CHANNELS];
    logic [7:0] cfgReg [CHANNELS];
    wire  [2:0] rdCh = isPort ? indPage[2:0] : cmdPage[2:0];

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : gCh
            wire hit = wrPage == PAGE_GLOBAL || wrPage == 8'(ch);
            wire [1:0] opCtrl = opReg[ch][OP_CTRL_LSB+:2];
            wire useBus  = cfgReg[ch][CFG_USE_BUS_BIT];
            wire usePin  = cfgReg[ch][CFG_USE_PIN_BIT];
            wire ctrlOn  = cfgReg[ch][CFG_CTRL_ON_BIT];
            wire fastBit = cfgReg[ch][CFG_FAST_OFF_BIT];
            wire busOn   = ~useBus | (opCtrl == CTRL_ON);
            wire pinOn   = ~usePin | pinAsserted;
            wire neverOn = ctrlOn & ~useBus & ~usePin;
            wire wantOn  = ~ctrlOn | (~neverOn & busOn & pinOn);
            wire busNow  = useBus & (opCtrl == CTRL_OFF_NOW);
            wire pinNow  = usePin & ~pinAsserted & fastBit;
            wire fastOff = busNow | pinNow;
            psm_ch_state_t    state;
            psm_ch_state_t    next_state;
            logic [CNT_W-1:0] cnt;
            wire tonDone  = cnt >= CNT_W'(TON_DELAY_CYCLES - 1);
            wire toffDone = cnt >= CNT_W'(TOFF_DELAY_CYCLES - 1);

            always_ff @(posedge sys_clk) begin
                if (!reset_n) begin
                    opReg[ch]  <= OP_RESET;
                    cfgReg[ch] <= CFG_RESET;
                end else begin
                    if (wrOp && hit && opLegal) begin
                        opReg[ch] <= {wrByte[7:2], 2'b00};
                    end
                    if (wrCfg && hit) begin
                        cfgReg[ch] <= {3'b000, wrByte[4:2], 1'b1,
                                       wrByte[0]};
                    end
                end
            end

            always_comb begin
                next_state = state;
                unique case (state)
                    CH_OFF: begin
                        if (wantOn && seqReady) next_state = CH_TON;
                    end
                    CH_TON: begin
                        if (!wantOn) next_state = CH_OFF;
                        else if (tonDone) next_state = CH_ON;
                    end
                    CH_ON: begin
                        if (!wantOn) begin
                            next_state = fastOff ? CH_OFF : CH_TOFF;
                        end
                    end
                    CH_TOFF: begin
                        if (wantOn) next_state = CH_ON;
                        else if (fastOff || toffDone) next_state = CH_OFF;
                    end
                endcase
            end

            always_ff @(posedge sys_clk) begin
                if (!reset_n) begin
                    state <= CH_OFF;
                    cnt   <= '0;
                end else begin
                    state <= next_state;
                    cnt   <= (next_state == state) ? cnt + 1'b1 : '0;
                end
            end

            always_ff @(posedge sys_clk) begin
                if (!reset_n) begin
                    converterEnableOutput[ch] <= 1'b0;
                    marginSelect[2*ch+:2]     <= MARG_NOMINAL;
                    faultsIgnored[ch]         <= 1'b0;
                end else begin
                    converterEnableOutput[ch] <= next_state == CH_ON ||
                                                 next_state == CH_TOFF;
                    marginSelect[2*ch+:2] <= opReg[ch][OP_MARG_LSB+:2];
                    faultsIgnored[ch] <= opReg[ch][OP_MARG_LSB+:2] !=
                        MARG_NOMINAL && opReg[ch][OP_FLT_LSB+:2] ==
                        FLT_IGNORE;
                end
            end
        end
    endgenerate

    // Read data selection.
    // Compared one bit wider so that a full set of eight channels fits.
    wire       chOk     = {1'b0, rdCh} < 4'(CHANNELS);
    wire [7:0] opRd     = chOk ? opReg[rdCh] : 8'h00;
    wire [7:0] cfgRd    = chOk ? cfgReg[rdCh] : 8'h00;
    wire       peekPg   = pageLegal;
    wire [15:0] stat0   = {14'h0000, pokeFailed[0], 1'b0};
    wire [15:0] stat1   = {14'h0000, pokeFailed[1], 1'b0};
    wire [15:0] peekData =
        !peekPg                   ? 16'h0000 :
        indPtr == PTR_STATUS0     ? stat0 :
        indPtr == PTR_STATUS1     ? stat1 :
        isOpPtr                   ? {8'h00, opRd} :
        isCfgPtr                  ? {8'h00, cfgRd} :
        userMem[memIdx];
    wire       directPgOk = cmdPage == PAGE_GLOBAL ||
                            cmdPage < 8'(CHANNELS);
    wire [15:0] rdData =
        isPort                              ? peekData :
        cmdCode == CODE_ON_OFF_MARGIN       ? {8'h00, opRd} :
        cmdCode == CODE_ON_OFF_CONFIG       ? {8'h00, cfgRd} :
        16'h0000;
    wire       rdBad = isRd && !isPort && !((cmdCode == CODE_ON_OFF_MARGIN ||
                       cmdCode == CODE_ON_OFF_CONFIG) && directPgOk);
    wire       wrBad = isWr && !isInd && !isPort && !directOp && !directCfg;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cmdRvalid <= 1'b0;
            cmdRdata  <= 16'h0000;
            cmdReject <= 1'b0;
        end else begin
            cmdRvalid <= isRd;
            cmdRdata  <= isRd ? rdData : 16'h0000;
            cmdReject <= rdBad | wrBad | directBad;
        end
    end
endmodule

// ### logic/psm_pkg.sv
// Shared constants and types for the power manager command block.
package psm_pkg;
    // Command codes seen on the command port.
    localparam logic [7:0]  CODE_ON_OFF_MARGIN  = 8'h01;
    localparam logic [7:0]  CODE_ON_OFF_CONFIG  = 8'h02;
    localparam logic [7:0]  CODE_INDIRECT_CMD   = 8'hE4;
    localparam logic [7:0]  CODE_DATA_PORT0     = 8'hE5;
    localparam logic [7:0]  CODE_DATA_PORT1     = 8'hE6;
    localparam logic [7:0]  PAGE_GLOBAL         = 8'hFF;
    localparam logic [4:0]  PAGE_MAX            = 5'h07;
    // Indirect pointer locations of the two poke status words.
    localparam logic [8:0]  PTR_STATUS0         = 9'h02C;
    localparam logic [8:0]  PTR_STATUS1         = 9'h02D;
    // Special indirect command values that open and close the data ports.
    localparam logic [15:0] POKE_EN0            = 16'h0BF6;
    localparam logic [15:0] POKE_DIS0           = 16'h01F6;
    localparam logic [15:0] POKE_EN1            = 16'h4BF6;
    localparam logic [15:0] POKE_DIS1           = 16'h41F6;
    // Indirect command word fields.
    localparam int          IND_HOST_BIT        = 14;
    localparam int          IND_PAGE_MSB        = 13;
    localparam int          IND_PAGE_LSB        = 9;
    localparam int          IND_PTR_MSB         = 8;
    // On/off-margin command fields and encodings.
    localparam int          OP_CTRL_LSB         = 6;
    localparam int          OP_MARG_LSB         = 4;
    localparam int          OP_FLT_LSB          = 2;
    localparam logic [1:0]  CTRL_OFF_NOW        = 2'h0;
    localparam logic [1:0]  CTRL_SEQ_OFF        = 2'h1;
    localparam logic [1:0]  CTRL_ON             = 2'h2;
    localparam logic [1:0]  MARG_NOMINAL        = 2'h0;
    localparam logic [1:0]  FLT_IGNORE          = 2'h1;
    localparam logic [1:0]  FLT_NORMAL          = 2'h2;
    // On/off configuration fields.
    localparam int          CFG_CTRL_ON_BIT     = 4;
    localparam int          CFG_USE_BUS_BIT     = 3;
    localparam int          CFG_USE_PIN_BIT     = 2;
    localparam int          CFG_FAST_OFF_BIT    = 0;
    // Reset values.
    localparam logic [7:0]  OP_RESET            = 8'h80;
    localparam logic [7:0]  CFG_RESET           = 8'h1E;
    // Timing.
    localparam int          CLK_PERIOD_NS       = 10;
    localparam int          INIT_TIME_US        = 100;
    localparam int          TON_DELAY_US        = 10;
    localparam int          TOFF_DELAY_US       = 10;
    typedef enum logic [1:0] {
        CH_OFF   = 2'b00,
        CH_TON   = 2'b01,
        CH_ON    = 2'b10,
        CH_TOFF  = 2'b11
    } psm_ch_state_t;
endpackage

// ### verif/psm_indirect_on_off_props.sv
// Concurrent checks on the command port and channel outputs.
`timescale 1ns/10ps
module psm_indirect_on_off_props
    import psm_pkg::*;
#(
    parameter int CHANNELS    = 8,
    parameter int INIT_CYCLES = 4
) (
    input  wire logic                  sys_clk,
    input  wire logic                  reset_n,
    input  wire logic                  cmdValid,
    input  wire logic                  cmdWrite,
    input  wire logic [7:0]            cmdCode,
    input  wire logic [7:0]            cmdPage,
    input  wire logic [15:0]           cmdWdata,
    input  wire logic                  cmdRvalid,
    input  wire logic [15:0]           cmdRdata,
    input  wire logic                  cmdReject,
    input  wire logic                  onOffInputPin_n,
    input  wire logic                  watchdogInput,
    input  wire logic                  inputVoltageSenseOk,
    input  wire logic [CHANNELS-1:0]   converterEnableOutput,
    input  wire logic [2*CHANNELS-1:0] marginSelect,
    input  wire logic [CHANNELS-1:0]   faultsIgnored,
    input  wire logic                  initDone
);
    int upCnt;
    wire logic rdReq = cmdValid && !cmdWrite;
    wire logic opWr = cmdValid && cmdWrite && cmdCode == CODE_ON_OFF_MARGIN;
    always_ff @(posedge sys_clk)
        if (!reset_n)
            upCnt <= 0;
        else if (upCnt < INIT_CYCLES)
            upCnt <= upCnt + 1;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    property p_port_answer;
        rdReq && cmdCode == CODE_DATA_PORT0 |=> cmdRvalid;
    endproperty
    a_port_answer: assert property (p_port_answer)
        else $error("data port read got no answer");
    property p_no_stray_rvalid;
        !rdReq |=> !cmdRvalid && cmdRdata == 16'h0000;
    endproperty
    a_no_stray_rvalid: assert property (p_no_stray_rvalid)
        else $error("read answer without a read");
    property p_cfg_read;
        rdReq && cmdCode == CODE_ON_OFF_CONFIG && cmdPage == 8'h00
        |=> cmdRvalid && cmdRdata[15:5] == 11'h000 && cmdRdata[1];
    endproperty
    a_cfg_read: assert property (p_cfg_read)
        else $error("config reserved bits read wrong");
    property p_op_read;
        rdReq && cmdCode == CODE_ON_OFF_MARGIN && cmdPage == 8'h00
        |=> cmdRvalid && cmdRdata[15:8] == 8'h00 && cmdRdata[1:0] == 2'h0;
    endproperty
    a_op_read: assert property (p_op_read)
        else $error("on/off-margin reserved bits read wrong");
    property p_op_reserved;
        opWr && cmdPage == PAGE_GLOBAL && cmdWdata[7:6] == 2'h3
        |=> cmdReject;
    endproperty
    a_op_reserved: assert property (p_op_reserved)
        else $error("reserved on/off value accepted");
    property p_op_global;
        opWr && cmdPage == PAGE_GLOBAL && cmdWdata[7:0] == 8'h80
        |=> !cmdReject;
    endproperty
    a_op_global: assert property (p_op_global)
        else $error("global page write refused");
    property p_poke_quiet;
        cmdValid && cmdWrite && cmdCode == CODE_DATA_PORT0 |=> !cmdReject;
    endproperty
    a_poke_quiet: assert property (p_poke_quiet)
        else $error("poke answered with a reject pulse");
    property p_init_time;
        initDone == (upCnt == INIT_CYCLES);
    endproperty
    a_init_time: assert property (p_init_time)
        else $error("init done at the wrong time");
    property p_no_early_on;
        !initDone |-> converterEnableOutput == '0;
    endproperty
    a_no_early_on: assert property (p_no_early_on)
        else $error("output enabled before init");
    property p_ignore_needs_margin;
        faultsIgnored[0] |-> marginSelect[1:0] != MARG_NOMINAL;
    endproperty
    a_ignore_needs_margin: assert property (p_ignore_needs_margin)
        else $error("faults ignored at nominal");
endmodule
bind psm_indirect_on_off psm_indirect_on_off_props #(
    .CHANNELS(CHANNELS), .INIT_CYCLES(INIT_CYCLES)
) chk_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdPage(cmdPage),
    .cmdWdata(cmdWdata), .cmdRvalid(cmdRvalid), .cmdRdata(cmdRdata),
    .cmdReject(cmdReject), .onOffInputPin_n(onOffInputPin_n),
    .watchdogInput(watchdogInput),
    .inputVoltageSenseOk(inputVoltageSenseOk),
    .converterEnableOutput(converterEnableOutput),
    .marginSelect(marginSelect), .faultsIgnored(faultsIgnored),
    .initDone(initDone)
);

// ### verif/psm_host_model.sv
// Host controller side of the command port, one command per call.
`timescale 1ns/10ps
module psm_host_model (
    input  wire logic        sys_clk,
    input  wire logic        cmdRvalid,
    input  wire logic [15:0] cmdRdata,
    input  wire logic        cmdReject,
    output logic             cmdValid,
    output logic             cmdWrite,
    output logic [7:0]       cmdCode,
    output logic [7:0]       cmdPage,
    output logic [15:0]      cmdWdata
);
    initial begin
        cmdValid = 1'b0;
        cmdWrite = 1'b0;
        cmdCode = 8'h00;
        cmdPage = 8'h00;
        cmdWdata = 16'h0000;
    end
    // Released fields turn inverted so a stale value is never trusted.
    task automatic xfer(input logic w, input logic [7:0] c, p,
                        input logic [15:0] d, output logic [15:0] rd,
                        output logic rj);
        @(negedge sys_clk);
        cmdValid = 1'b1;
        cmdWrite = w;
        cmdCode = c;
        cmdPage = p;
        cmdWdata = d;
        @(negedge sys_clk);
        cmdValid = 1'b0;
        cmdWrite = ~w;
        cmdCode = ~c;
        cmdPage = ~p;
        cmdWdata = ~d;
        rd = cmdRvalid ? cmdRdata : 16'hXXXX;
        rj = cmdReject;
    endtask
endmodule

// ### verif/tb_psm_indirect_access_on_off.sv
// Self-checking bench for the indirect access and on/off block.
`timescale 1ns/10ps
module tb_psm_indirect_access_on_off
    import psm_pkg::*;
();
    localparam int MIN_OFF = 8;
    logic sysClk = 1'b0;
    logic resetN = 1'b0;
    logic pinN = 1'b1;
    logic wdog = 1'b0;
    logic vinOk = 1'b0;
    logic lastRej;
    logic [31:0] rng = 32'hC58749B9;
    int n_errors = 0;
    int cmp_count = 0;
    wire logic cV, cW, rV, rJ, initDone;
    wire logic [7:0] cC, cP, enOut, fltIgn;
    wire logic [15:0] cD, rD, margin;
    always #5 sysClk = ~sysClk;
    psm_host_model host_u (.sys_clk(sysClk), .cmdRvalid(rV), .cmdRdata(rD),
        .cmdReject(rJ), .cmdValid(cV), .cmdWrite(cW), .cmdCode(cC),
        .cmdPage(cP), .cmdWdata(cD));
    psm_indirect_on_off #(.CHANNELS(8), .INIT_CYCLES(4),
        .TON_DELAY_CYCLES(4), .TOFF_DELAY_CYCLES(4)) dut_u (
        .sys_clk(sysClk), .reset_n(resetN), .cmdValid(cV), .cmdWrite(cW),
        .cmdCode(cC), .cmdPage(cP), .cmdWdata(cD), .cmdRvalid(rV),
        .cmdRdata(rD), .cmdReject(rJ), .onOffInputPin_n(pinN),
        .watchdogInput(wdog), .inputVoltageSenseOk(vinOk),
        .converterEnableOutput(enOut), .marginSelect(margin),
        .faultsIgnored(fltIgn), .initDone(initDone));
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    function automatic logic opLegal(input logic [7:0] v);
        return v[7:6] != 2'h3 && v[5:4] != 2'h3
            && (v[5:4] == 2'h0 || v[3:2] == 2'h1 || v[3:2] == 2'h2);
    endfunction
    function automatic logic [15:0] ind(input int h, input logic [4:0] pg,
                                        input logic [8:0] ptr);
        return {1'b0, h[0], pg, ptr};
    endfunction
    task automatic stop_test;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] c, p, input logic [15:0] d);
        logic [15:0] r;
        host_u.xfer(1'b1, c, p, d, r, lastRej);
    endtask
    task automatic rd(input logic [7:0] c, p, output logic [15:0] r);
        logic j;
        host_u.xfer(1'b0, c, p, 16'h0000, r, j);
    endtask
    task automatic peek(input int h, input logic [4:0] pg,
                        output logic [15:0] r);
        wr(CODE_INDIRECT_CMD, 8'h00, ind(h, pg, 9'h100));
        rd(h ? CODE_DATA_PORT1 : CODE_DATA_PORT0, 8'h00, r);
    endtask
    // Pokes a word, then reads the write-failed flag of the same port.
    task automatic pokeTry(input int h, input logic [4:0] pg,
                           input logic [15:0] d, input logic fail);
        logic [15:0] r;
        wr(CODE_INDIRECT_CMD, 8'h00, ind(h, pg, 9'h100));
        wr(h ? CODE_DATA_PORT1 : CODE_DATA_PORT0, 8'h00, d);
        wr(CODE_INDIRECT_CMD, 8'h00,
           ind(h, 5'h00, h ? PTR_STATUS1 : PTR_STATUS0));
        rd(h ? CODE_DATA_PORT1 : CODE_DATA_PORT0, 8'h00, r);
        check("poke failed flag", {15'h0000, r[1]}, {15'h0000, fail});
    endtask
    task automatic waitEn(input string what, input logic [7:0] e, input int n);
        for (int i = 0; i < n && enOut !== e; i++)
            @(negedge sysClk);
        check(what, {8'h00, enOut}, {8'h00, e});
        if (enOut !== e)
            stop_test();
    endtask
    task automatic cfgOp(input logic [7:0] cfg, op);
        wr(CODE_ON_OFF_CONFIG, PAGE_GLOBAL, {8'h00, cfg});
        wr(CODE_ON_OFF_MARGIN, PAGE_GLOBAL, {8'h00, op});
    endtask
    initial begin
        repeat (100000) @(posedge sysClk);
        n_errors++;
        stop_test();
    end
    initial begin
        logic [15:0] r;
        logic [15:0] dat [2];
        logic [7:0] v;
        logic [7:0] last;
        repeat (20) @(negedge sysClk);
        resetN = 1'b1;
        rd(CODE_ON_OFF_MARGIN, 8'h00, r);
        check("op reset", r, {8'h00, OP_RESET});
        rd(CODE_ON_OFF_CONFIG, 8'h00, r);
        check("cfg reset", r, {8'h00, CFG_RESET});
        repeat (8) begin
            rng = xs(rng);
            wr(CODE_ON_OFF_CONFIG, PAGE_GLOBAL, {8'h00, rng[7:0]});
            rd(CODE_ON_OFF_CONFIG, 8'h00, r);
            check("cfg rb", r, {8'h00, rng[7:0] & 8'h1D | 8'h02});
        end
        wr(CODE_ON_OFF_CONFIG, PAGE_GLOBAL, 16'h001E);
        last = OP_RESET;
        for (int h = 0; h < 64; h++) begin
            v = 8'(h << 2);
            wr(CODE_ON_OFF_MARGIN, PAGE_GLOBAL, {8'h00, v});
            check("op rej", {15'h0, lastRej}, {15'h0, !opLegal(v)});
            if (opLegal(v))
                last = v;
            rd(CODE_ON_OFF_MARGIN, 8'h03, r);
            check("op rb", r, {8'h00, last});
        end
        for (int h = 0; h < 2; h++) begin
            rng = xs(rng);
            dat[h] = rng[15:0];
            pokeTry(h, 5'(3 + 2 * h), 16'hA5A5, 1'b1);
            wr(CODE_INDIRECT_CMD, 8'h00, h ? POKE_EN1 : POKE_EN0);
            pokeTry(h, 5'(3 + 2 * h), dat[h], 1'b0);
            pokeTry(h, 5'h09, 16'h5A5A, 1'b1);
        end
        wr(CODE_INDIRECT_CMD, 8'h00, ind(0, 5'h03, 9'h100));
        wr(CODE_INDIRECT_CMD, 8'h00, ind(1, 5'h05, 9'h100));
        rd(CODE_DATA_PORT0, 8'h00, r);
        check("port0 cache", r, dat[0]);
        rd(CODE_DATA_PORT1, 8'h00, r);
        check("port1 cache", r, dat[1]);
        wr(CODE_INDIRECT_CMD, 8'h00, ind(0, 5'h00, 9'h002));
        rd(CODE_DATA_PORT0, 8'h00, r);
        check("byte peek", r, 16'h001E);
        wr(CODE_INDIRECT_CMD, 8'h00, POKE_DIS0);
        pokeTry(0, 5'h03, ~dat[0], 1'b1);
        peek(0, 5'h03, r);
        check("kept data", r, dat[0]);
        wr(CODE_INDIRECT_CMD, 8'h00, POKE_DIS1);
        pokeTry(1, 5'h05, ~dat[1], 1'b1);
        wr(CODE_INDIRECT_CMD, 8'h00, POKE_EN1);
        pokeTry(1, 5'h05, dat[0], 1'b0);
        wdog = 1'b1;
        repeat (4) @(negedge sysClk);
        wdog = 1'b0;
        repeat (4) @(negedge sysClk);
        pokeTry(1, 5'h05, dat[1], 1'b1);
        cfgOp(8'h1E, 8'h80);
        pinN = 1'b0;
        repeat (12) @(negedge sysClk);
        check("vin low", {8'h00, enOut}, 16'h0000);
        vinOk = 1'b1;
        waitEn("pin on", 8'hFF, 20);
        pinN = 1'b1;
        repeat (4) @(negedge sysClk);
        check("delayed off", {8'h00, enOut}, 16'h00FF);
        waitEn("slow off", 8'h00, 12);
        repeat (MIN_OFF) @(negedge sysClk);
        wr(CODE_ON_OFF_CONFIG, PAGE_GLOBAL, 16'h001F);
        pinN = 1'b0;
        waitEn("pin on", 8'hFF, 20);
        pinN = 1'b1;
        waitEn("fast off", 8'h00, 4);
        repeat (MIN_OFF) @(negedge sysClk);
        cfgOp(8'h1A, 8'h80);
        waitEn("bus on", 8'hFF, 20);
        wr(CODE_ON_OFF_MARGIN, PAGE_GLOBAL, 16'h0000);
        waitEn("bus off now", 8'h00, 3);
        repeat (MIN_OFF) @(negedge sysClk);
        wr(CODE_ON_OFF_MARGIN, PAGE_GLOBAL, 16'h0080);
        waitEn("bus on", 8'hFF, 20);
        wr(CODE_ON_OFF_MARGIN, PAGE_GLOBAL, 16'h0040);
        waitEn("seq off", 8'h00, 12);
        repeat (MIN_OFF) @(negedge sysClk);
        cfgOp(8'h12, 8'h80);
        pinN = 1'b0;
        repeat (20) @(negedge sysClk);
        check("never on", {8'h00, enOut}, 16'h0000);
        pinN = 1'b1;
        cfgOp(8'h16, 8'h14);
        repeat (3) @(negedge sysClk);
        check("margin low", margin, 16'h5555);
        check("flt ignore", {8'h00, fltIgn}, 16'h00FF);
        pinN = 1'b0;
        waitEn("bus ignored", 8'hFF, 20);
        pinN = 1'b1;
        waitEn("pin off", 8'h00, 12);
        repeat (MIN_OFF) @(negedge sysClk);
        cfgOp(8'h0E, 8'h00);
        waitEn("auto on", 8'hFF, 20);
        stop_test();
    end
endmodule
